// File: rtl/wcs_pkg.sv
// Purpose: Shared constants and types for the weld cycle sequencer
// Assumes: 50 MHz mclk, all programmed times in whole milliseconds
// Notes:   Times are given in ms; cycle counts derive from the clock rate
package wcs_pkg;

  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned TICK_US       = 1000;
  localparam int unsigned TICK_CYCLES   = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned TIME_W        = 15;
  localparam int unsigned ENERGY_W      = 24;
  localparam int unsigned SCRUB_MAX_MS  = 150;
  localparam int unsigned BURST_MAX_MS  = 999;
  localparam int unsigned DELAY_MAX_MS  = 30000;
  localparam logic [TIME_W-1:0] TIME_RST = 15'h0000;

  typedef enum logic [1:0] {
    WCS_TRIG_UNTIMED = 2'h0,
    WCS_TRIG_TIMED   = 2'h1
  } wcs_trig_type;

  typedef enum logic [1:0] {
    WCS_METH_TIME   = 2'h0,
    WCS_METH_ENERGY = 2'h1,
    WCS_METH_GROUND = 2'h2
  } wcs_meth_type;

  // Gray sequence in declaration order
  typedef enum logic [2:0] {
    WCS_ST_READY = 3'h0,
    WCS_ST_DELAY = 3'h1,
    WCS_ST_WELD  = 3'h3,
    WCS_ST_SCRUB = 3'h2,
    WCS_ST_HOLD  = 3'h6,
    WCS_ST_ABDLY = 3'h7,
    WCS_ST_BURST = 3'h5,
    WCS_ST_WAIT  = 3'h4
  } wcs_state_type;

endpackage

// File: rtl/wcs_timer_if.sv
// Purpose: Carrier between sequencer and its millisecond timer
// Assumes: One clock domain
// Notes:   restart zeroes the count; ms_count saturates
`timescale 1ns/1ps
interface wcs_timer_if;
  logic                        restart;
  logic [wcs_pkg::TIME_W-1:0]  ms_count;
  modport ctrl (output restart, input ms_count);
  modport tmr  (input restart, output ms_count);
endinterface

// File: rtl/wcs_ms_timer.sv
// Purpose: Millisecond phase timer for the weld sequencer
// Assumes: mclk at wcs_pkg::CLK_HZ
// Notes:   Count saturates instead of wrapping so a stuck phase never re-fires
`timescale 1ns/1ps
module wcs_ms_timer #(
  parameter int unsigned TICK = wcs_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset_n,
  // Timer carrier
  wcs_timer_if.tmr  tif
);

  logic [15:0]               pre;
  logic [wcs_pkg::TIME_W-1:0] cnt;
  wire                       tick = (pre == 16'(TICK - 1));
  wire                       sat  = &cnt;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pre <= 16'h0000;
      cnt <= wcs_pkg::TIME_RST;
    end else if (tif.restart) begin
      pre <= 16'h0000;
      cnt <= wcs_pkg::TIME_RST;
    end else begin
      pre <= tick ? 16'h0000 : pre + 16'h0001;
      if (tick && !sat)
        cnt <= cnt + 1'b1;
    end
  end

  assign tif.ms_count = cnt;

endmodule

// File: rtl/wcs_sequencer.sv
// Purpose: Sequences one ultrasonic weld cycle: delay, weld, scrub, hold, afterburst
// Assumes: Pins trigger, stop and ground come from outside and are synchronised here
// Notes:   Settings are sampled live; change them only while ready_to_weld_state is high
`timescale 1ns/1ps
module wcs_sequencer #(
  parameter int unsigned TICK = wcs_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         reset_n,
  // Setup
  input  wire logic                         setup_done,
  input  wire logic                         power_option,
  input  wire logic                         multi_probe_unit,
  input  wire wcs_pkg::wcs_trig_type        trig_mode,
  input  wire wcs_pkg::wcs_meth_type        weld_method,
  input  wire logic                         auto_stop_en,
  input  wire logic                         stop_all_position,
  input  wire logic                         stop_as_ground,
  input  wire logic [wcs_pkg::TIME_W-1:0]   delay_ms,
  input  wire logic [wcs_pkg::TIME_W-1:0]   weld_ms,
  input  wire logic [wcs_pkg::TIME_W-1:0]   max_weld_ms,
  input  wire logic [wcs_pkg::TIME_W-1:0]   scrub_ms,
  input  wire logic [wcs_pkg::TIME_W-1:0]   hold_ms,
  input  wire logic [wcs_pkg::TIME_W-1:0]   ab_delay_ms,
  input  wire logic [wcs_pkg::TIME_W-1:0]   ab_dur_ms,
  input  wire logic                         ab_enable,
  input  wire logic [wcs_pkg::ENERGY_W-1:0] energy_target,
  input  wire logic [wcs_pkg::ENERGY_W-1:0] energy_now,
  // Pins
  input  wire logic                         trigger_pin,
  input  wire logic                         auto_stop_pin,
  input  wire logic                         ground_pin,
  // Outputs
  output logic                              sonics_on,
  output logic                              hold_on,
  output logic                              retract,
  output logic                              ready_to_weld_state,
  output logic                              cycle_busy
);

  wcs_pkg::wcs_state_type state;
  wcs_pkg::wcs_state_type next_state;
  logic [1:0] trg_s, stp_s, gnd_s;
  logic       trg_d;
  logic       cap_abort;
  wcs_timer_if tif ();

  wcs_ms_timer #(.TICK(TICK)) u_timer (
    .mclk    (mclk),
    .reset_n (reset_n),
    .tif     (tif)
  );

  // Two-stage sync; logic reads only the second stage, never the first
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      trg_s <= 2'h0;
      stp_s <= 2'h0;
      gnd_s <= 2'h0;
      trg_d <= 1'b0;
    end else begin
      trg_s <= {trg_s[0], trigger_pin};
      stp_s <= {stp_s[0], auto_stop_pin};
      gnd_s <= {gnd_s[0], ground_pin};
      trg_d <= trg_s[1];
    end
  end

  wire trig_lvl  = trg_s[1];
  wire trig_rise = trg_s[1] & ~trg_d;
  wire stop_ok   = auto_stop_en & stp_s[1];
  wire contact   = gnd_s[1] | (multi_probe_unit & stop_as_ground & stop_ok);
  wire stop_cmd  = stop_ok & ~(multi_probe_unit & stop_as_ground);
  wire meth_en   = (weld_method == wcs_pkg::WCS_METH_ENERGY) & power_option;
  wire meth_gnd  = (weld_method == wcs_pkg::WCS_METH_GROUND) & multi_probe_unit;
  wire untimed   = (trig_mode == wcs_pkg::WCS_TRIG_UNTIMED);
  wire [wcs_pkg::TIME_W-1:0] t = tif.ms_count;
  wire [wcs_pkg::TIME_W-1:0] scrub_lim = (scrub_ms > 15'(wcs_pkg::SCRUB_MAX_MS)) ?
                                         15'(wcs_pkg::SCRUB_MAX_MS) : scrub_ms;
  wire [wcs_pkg::TIME_W-1:0] abd_lim = (ab_delay_ms > 15'(wcs_pkg::BURST_MAX_MS)) ?
                                       15'(wcs_pkg::BURST_MAX_MS) : ab_delay_ms;
  wire [wcs_pkg::TIME_W-1:0] abt_lim = (ab_dur_ms > 15'(wcs_pkg::BURST_MAX_MS)) ?
                                       15'(wcs_pkg::BURST_MAX_MS) : ab_dur_ms;
  // Cap timer runs in parallel with scrub, so track max time separately
  logic [wcs_pkg::TIME_W-1:0] weld_t;
  logic [15:0]                weld_pre;

  wire ready_now = setup_done & (state == wcs_pkg::WCS_ST_READY);
  wire start     = ready_now & trig_rise;
  wire rel_end   = ~trig_lvl & ~meth_gnd;
  wire time_end  = ~untimed & ~meth_en & ~meth_gnd & (weld_t >= weld_ms);
  wire nrg_end   = ~untimed & meth_en &
                   ((energy_now >= energy_target) | (weld_t >= max_weld_ms));
  wire max_gnd   = meth_gnd & (weld_t >= max_weld_ms);
  wire weld_end  = rel_end | time_end | nrg_end | max_gnd | stop_cmd;
  wire abort_all = stop_cmd & stop_all_position;

  always_comb begin
    next_state = state;
    case (state)
      wcs_pkg::WCS_ST_READY:
        if (start)
          next_state = (untimed && delay_ms != wcs_pkg::TIME_RST) ? wcs_pkg::WCS_ST_DELAY
                                                          : wcs_pkg::WCS_ST_WELD;
      wcs_pkg::WCS_ST_DELAY:
        if (!trig_lvl || abort_all)
          next_state = wcs_pkg::WCS_ST_WAIT;
        else if (t >= delay_ms)
          next_state = wcs_pkg::WCS_ST_WELD;
      wcs_pkg::WCS_ST_WELD:
        if (abort_all)
          next_state = wcs_pkg::WCS_ST_WAIT;
        else if (max_gnd || weld_end)
          next_state = wcs_pkg::WCS_ST_HOLD;
        else if (meth_gnd && contact)
          next_state = wcs_pkg::WCS_ST_SCRUB;
      wcs_pkg::WCS_ST_SCRUB:
        if (abort_all)
          next_state = wcs_pkg::WCS_ST_WAIT;
        else if (t >= scrub_lim || max_gnd)
          next_state = wcs_pkg::WCS_ST_HOLD;
      wcs_pkg::WCS_ST_HOLD:
        if (t >= hold_ms)
          next_state = ab_enable ? wcs_pkg::WCS_ST_ABDLY : wcs_pkg::WCS_ST_WAIT;
      wcs_pkg::WCS_ST_ABDLY:
        if (t >= abd_lim)
          next_state = wcs_pkg::WCS_ST_BURST;
      wcs_pkg::WCS_ST_BURST:
        if (t >= abt_lim)
          next_state = wcs_pkg::WCS_ST_WAIT;
      wcs_pkg::WCS_ST_WAIT:
        if (!trig_lvl)
          next_state = wcs_pkg::WCS_ST_READY;
      default:
        next_state = wcs_pkg::WCS_ST_READY;
    endcase
  end

  assign tif.restart = (next_state != state);
  wire weld_tick = (weld_pre == 16'(TICK - 1));

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state               <= wcs_pkg::WCS_ST_READY;
      weld_t              <= wcs_pkg::TIME_RST;
      weld_pre            <= 16'h0000;
      sonics_on           <= 1'b0;
      hold_on             <= 1'b0;
      retract             <= 1'b0;
      ready_to_weld_state <= 1'b0;
      cycle_busy          <= 1'b0;
      cap_abort           <= 1'b0;
    end else begin
      state <= next_state;
      if (state != wcs_pkg::WCS_ST_WELD && state != wcs_pkg::WCS_ST_SCRUB) begin
        weld_t   <= wcs_pkg::TIME_RST;
        weld_pre <= 16'h0000;
      end else begin
        weld_pre <= weld_tick ? 16'h0000 : weld_pre + 16'h0001;
        if (weld_tick && !(&weld_t))
          weld_t <= weld_t + 1'b1;
      end
      sonics_on  <= (next_state == wcs_pkg::WCS_ST_WELD) ||
                    (next_state == wcs_pkg::WCS_ST_SCRUB) ||
                    (next_state == wcs_pkg::WCS_ST_BURST);
      hold_on    <= (next_state == wcs_pkg::WCS_ST_HOLD);
      retract    <= (next_state == wcs_pkg::WCS_ST_ABDLY) ||
                    (next_state == wcs_pkg::WCS_ST_BURST);
      ready_to_weld_state <= setup_done && (next_state == wcs_pkg::WCS_ST_READY);
      cycle_busy <= (next_state != wcs_pkg::WCS_ST_READY);
      cap_abort  <= abort_all;
    end
  end

  // Checks
  a_energy_off: assert property (@(posedge mclk) disable iff (!reset_n)
    state == wcs_pkg::WCS_ST_WELD && nrg_end && !abort_all |=> hold_on && !sonics_on)
    else $error("energy end did not stop sonics");
  a_time_exact: assert property (@(posedge mclk) disable iff (!reset_n)
    state == wcs_pkg::WCS_ST_WELD && !untimed && !meth_en && !meth_gnd && !stop_cmd
      && trig_lvl && weld_t < weld_ms |=> sonics_on)
    else $error("timed weld ended early");
  a_stop_ignored: assert property (@(posedge mclk) disable iff (!reset_n)
    !auto_stop_en |-> !stop_cmd)
    else $error("stop recognised while disabled");
  a_stop_ends: assert property (@(posedge mclk) disable iff (!reset_n)
    state == wcs_pkg::WCS_ST_WELD && stop_cmd |=> !sonics_on)
    else $error("stop did not end weld");
  a_tail_runs: assert property (@(posedge mclk) disable iff (!reset_n)
    state == wcs_pkg::WCS_ST_WELD && stop_cmd && !stop_all_position |=> hold_on)
    else $error("hold skipped on end-of-weld stop");
  a_scrub_cap: assert property (@(posedge mclk) disable iff (!reset_n)
    state == wcs_pkg::WCS_ST_SCRUB |-> t <= 15'(wcs_pkg::SCRUB_MAX_MS))
    else $error("scrub exceeded limit");
  a_max_cap: assert property (@(posedge mclk) disable iff (!reset_n)
    meth_gnd && state == wcs_pkg::WCS_ST_SCRUB && max_gnd && !abort_all |=> !sonics_on)
    else $error("max weld time ignored");
  a_no_retrig: assert property (@(posedge mclk) disable iff (!reset_n)
    state inside {wcs_pkg::WCS_ST_HOLD, wcs_pkg::WCS_ST_ABDLY, wcs_pkg::WCS_ST_BURST,
                  wcs_pkg::WCS_ST_WAIT} |=>
      !(state inside {wcs_pkg::WCS_ST_DELAY, wcs_pkg::WCS_ST_WELD}))
    else $error("retrigger during cycle");
  a_ready_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    state == wcs_pkg::WCS_ST_READY && !setup_done |=> state == wcs_pkg::WCS_ST_READY)
    else $error("trigger accepted before setup");
  c_weld: cover property (@(posedge mclk) disable iff (!reset_n)
    state == wcs_pkg::WCS_ST_WELD ##1 state == wcs_pkg::WCS_ST_HOLD);
  c_scrub: cover property (@(posedge mclk) disable iff (!reset_n)
    state == wcs_pkg::WCS_ST_SCRUB);
  c_burst: cover property (@(posedge mclk) disable iff (!reset_n)
    state == wcs_pkg::WCS_ST_BURST);
  c_abort: cover property (@(posedge mclk) disable iff (!reset_n) cap_abort);

endmodule

// File: sim/wcs_field_model.sv
// Purpose: Operator trigger, automation stop and fixture contact for the sequencer
// Assumes: Lines change on falling mclk edges; times are in ms of tick cycles
// Notes:   A released line falls to 0, as a pull-down would leave it
`timescale 1ns/1ps
module wcs_field_model (
  // Clock
  input  wire logic mclk,
  // Pins towards the sequencer
  output logic      trigger_pin,
  output logic      auto_stop_pin,
  output logic      ground_pin
);
  logic [2:0] pins = 3'h0;

  assign {ground_pin, auto_stop_pin, trigger_pin} = pins;

  task automatic pulse(input int sel, input int t0, input int t1);
    repeat (t0) @(negedge mclk);
    pins[sel] = 1'b1;
    repeat (t1 - t0) @(negedge mclk);
    pins[sel] = 1'b0;
  endtask

  // Contact stays closed until the operator lets go, as a real fixture would
  task automatic act(input int trig, input int stop, input int gnd, input int tick);
    fork
      pulse(0, 0, trig * tick);
      if (stop > 0) pulse(1, stop * tick, (stop + 2) * tick);
      if (gnd > 0) pulse(2, gnd * tick, trig * tick);
    join_none
  endtask
endmodule

// File: sim/tb_top.sv
// Purpose: Self-checking bench for the weld cycle sequencer
// Assumes: TICK shortened to 20 cycles per ms
// Notes:   Energy input ramps one unit per cycle of sonics
`timescale 1ns/1ps
module tb_top;
  localparam int TICK = 20;
  logic                         mclk, reset_n, setup_done, power_option, multi_probe_unit;
  logic                         auto_stop_en, stop_all_position, stop_as_ground, ab_enable;
  wcs_pkg::wcs_trig_type        trig_mode;
  wcs_pkg::wcs_meth_type        weld_method;
  logic [wcs_pkg::TIME_W-1:0]   delay_ms, weld_ms, max_weld_ms, scrub_ms;
  logic [wcs_pkg::TIME_W-1:0]   hold_ms, ab_delay_ms, ab_dur_ms;
  logic [wcs_pkg::ENERGY_W-1:0] energy_target, energy_now;
  logic                         trigger_pin, auto_stop_pin, ground_pin;
  logic                         sonics_on, hold_on, retract, ready_to_weld_state, cycle_busy;
  int                           failures, n_compared, cycles, hits;

  wcs_sequencer #(.TICK(TICK)) u_dut (
    .mclk(mclk), .reset_n(reset_n), .setup_done(setup_done),
    .power_option(power_option), .multi_probe_unit(multi_probe_unit),
    .trig_mode(trig_mode), .weld_method(weld_method), .auto_stop_en(auto_stop_en),
    .stop_all_position(stop_all_position), .stop_as_ground(stop_as_ground),
    .delay_ms(delay_ms), .weld_ms(weld_ms), .max_weld_ms(max_weld_ms),
    .scrub_ms(scrub_ms), .hold_ms(hold_ms), .ab_delay_ms(ab_delay_ms),
    .ab_dur_ms(ab_dur_ms), .ab_enable(ab_enable), .energy_target(energy_target),
    .energy_now(energy_now), .trigger_pin(trigger_pin), .auto_stop_pin(auto_stop_pin),
    .ground_pin(ground_pin), .sonics_on(sonics_on), .hold_on(hold_on),
    .retract(retract), .ready_to_weld_state(ready_to_weld_state), .cycle_busy(cycle_busy)
  );

  wcs_field_model u_field (
    .mclk(mclk), .trigger_pin(trigger_pin), .auto_stop_pin(auto_stop_pin),
    .ground_pin(ground_pin)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Accumulated energy, cleared between cycles
  always @(negedge mclk) begin
    energy_now <= (sonics_on === 1'b1) ? energy_now + 24'h00_0001 :
                  ((cycle_busy === 1'b1) ? energy_now : 24'h00_0000);
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      $display("Error at %0t: timeout", $time);
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input int got, input int exp, input int tol, input string what);
    n_compared++;
    if (got > exp + tol || got < exp - tol) begin
      failures++;
      $display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  task automatic defaults();
    setup_done = 1'b1;
    power_option = 1'b1;
    multi_probe_unit = 1'b1;
    trig_mode = wcs_pkg::WCS_TRIG_TIMED;
    weld_method = wcs_pkg::WCS_METH_TIME;
    auto_stop_en = 1'b0;
    stop_all_position = 1'b0;
    stop_as_ground = 1'b0;
    ab_enable = 1'b0;
    delay_ms = 15'h0000;
    weld_ms = 15'h0005;
    max_weld_ms = 15'h0014;
    scrub_ms = 15'h0003;
    hold_ms = 15'h0002;
    ab_delay_ms = 15'h0002;
    ab_dur_ms = 15'h0003;
    energy_target = 24'h00_0050;
  endtask

  // Expected sonics time in ms from the settings now applied
  function automatic int exp_ms(input int t, input int stop, input int gnd);
    int lim;
    wcs_pkg::wcs_meth_type m;
    m = weld_method;
    if (m == wcs_pkg::WCS_METH_ENERGY && power_option !== 1'b1) m = wcs_pkg::WCS_METH_TIME;
    if (m == wcs_pkg::WCS_METH_GROUND) begin
      if (stop_as_ground === 1'b1 && auto_stop_en === 1'b1) gnd = stop;
      lim = int'(max_weld_ms);
      if (gnd > 0 && gnd + int'(scrub_ms) < lim) lim = gnd + int'(scrub_ms);
      return lim;
    end
    lim = t;
    if (trig_mode == wcs_pkg::WCS_TRIG_TIMED) begin
      if (m == wcs_pkg::WCS_METH_ENERGY) begin
        lim = int'(energy_target) / TICK;
        if (int'(max_weld_ms) < lim) lim = int'(max_weld_ms);
      end else begin
        lim = int'(weld_ms);
      end
      if (t < lim) lim = t;
    end
    if (auto_stop_en === 1'b1 && stop > 0 && stop < lim) lim = stop;
    return lim;
  endfunction

  task automatic run(input int trig, input int stop, input int gnd, input string name);
    int w, s, h, r, b, dly, ab, tail;
    w = 0;
    s = 0;
    h = 0;
    r = 0;
    b = 0;
    dly = (trig_mode == wcs_pkg::WCS_TRIG_UNTIMED) ? int'(delay_ms) : 0;
    ab = (ab_enable === 1'b1) ? 1 : 0;
    // A full-stop routing skips hold and afterburst
    tail = (auto_stop_en === 1'b1 && stop_all_position === 1'b1 && stop > 0
            && stop_as_ground !== 1'b1) ? 0 : 1;
    u_field.act(trig, stop, gnd, TICK);
    while (sonics_on !== 1'b1 && w < 4000) begin
      @(negedge mclk);
      w++;
    end
    chk(int'(cycle_busy === 1'b1), 1, 0, "busy");
    while (sonics_on === 1'b1) begin
      @(negedge mclk);
      s++;
    end
    while (hold_on === 1'b1) begin
      @(negedge mclk);
      h++;
    end
    while (retract === 1'b1) begin
      if (sonics_on === 1'b1) b++;
      @(negedge mclk);
      r++;
    end
    chk(w, dly * TICK + 4, 5, "start");
    chk(s, exp_ms(trig - dly, stop, gnd) * TICK, 5, "sonics");
    chk(h, tail * int'(hold_ms) * TICK, 5, "hold");
    chk(r, tail * ab * int'(ab_delay_ms + ab_dur_ms) * TICK, 5, "retract");
    chk(b, tail * ab * int'(ab_dur_ms) * TICK, 5, "burst");
    while (ready_to_weld_state !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    $display("Done %s at %0t", name, $time);
  endtask

  initial begin
    failures = 0;
    n_compared = 0;
    cycles = 0;
    hits = 0;
    energy_now = 24'h00_0000;
    defaults();
    reset_n = 1'b0;
    repeat (20) @(negedge mclk);
    reset_n = 1'b1;
    repeat (2) @(negedge mclk);
    chk(int'(ready_to_weld_state === 1'b1), 1, 0, "ready");
    void'($urandom(10200));
    trig_mode = wcs_pkg::WCS_TRIG_UNTIMED;
    run(6, 0, 0, "untimed");
    delay_ms = 15'h0003;
    run(10, 0, 0, "probe delay");
    defaults();
    repeat (4) begin
      weld_ms = 15'(3 + $urandom_range(7));
      hold_ms = 15'(1 + $urandom_range(3));
      run(30, 0, 0, "timed");
    end
    defaults();
    weld_ms = 15'h0008;
    run(3, 0, 0, "early release");
    weld_method = wcs_pkg::WCS_METH_ENERGY;
    run(30, 0, 0, "energy");
    energy_target = 24'h00_FFFF;
    max_weld_ms = 15'h0007;
    run(30, 0, 0, "energy cap");
    power_option = 1'b0;
    run(30, 0, 0, "no energy option");
    defaults();
    weld_ms = 15'h000A;
    auto_stop_en = 1'b1;
    ab_enable = 1'b1;
    run(30, 3, 0, "auto stop");
    stop_all_position = 1'b1;
    run(30, 3, 0, "stop all");
    stop_all_position = 1'b0;
    auto_stop_en = 1'b0;
    run(30, 3, 0, "stop ignored");
    defaults();
    weld_method = wcs_pkg::WCS_METH_GROUND;
    run(30, 0, 4, "ground");
    max_weld_ms = 15'h0009;
    run(30, 0, 0, "ground cap");
    run(30, 0, 8, "scrub cap");
    max_weld_ms = 15'h0014;
    stop_as_ground = 1'b1;
    auto_stop_en = 1'b1;
    run(30, 4, 0, "stop as ground");
    defaults();
    setup_done = 1'b0;
    u_field.act(3, 0, 0, TICK);
    repeat (5 * TICK) begin
      @(negedge mclk);
      if (sonics_on !== 1'b0 || ready_to_weld_state !== 1'b0 || cycle_busy !== 1'b0) hits++;
    end
    chk(hits, 0, 0, "not ready");
    $display("Done not ready at %0t", $time);
    print_verdict();
  end
endmodule
